/* cmp_ctrl.sv */
// comparator digital control: registers, events, pin and capture routing
//
// How it works
// - block keeps running in light stop
// - pin output unchanged in light stop
// - edge detection active in light stop
// - stop event sets flag, requests wake-up if interrupt enabled
// - routing bit feeds comparator to capture zero
// - routing disconnects timer channel zero pin
// - block keeps running in wait
// - wait event with interrupt enabled wakes
// - reset from stop returns reset state
// - deep stop powers down, no events, pin
// - deep stop wake-up gives reset state
// - debug mode leaves operation unchanged
// - rising, falling or either edge selectable
// - select 00/10 fall, 01 rise, 11 both
// - flag set by event, write-one clears
// - interrupt asserted while flag and enable
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module cmp_ctrl
   import cmp_pkg::*;
(
   input wire logic mclk, // bus clock, 125 MHz
   input wire logic rst, // async reset, active high
   input wire logic [addr_w-1:0] addr, // register index
   input wire logic [7:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read data, cycle after rd
   input wire logic [1:0] power_mode, // current chip power mode
   input wire logic debug_active, // background debug active
   input wire logic analog_out, // raw comparator output
   input wire logic timer_pin_in, // level on timer channel 0 pin
   input wire logic timer_pin_out, // timer drive toward channel 0 pin
   output logic comparator_output_pin, // external comparator output pin data
   output logic comparator_output_pin_oe_n, // pin enable, low while driving
   output logic timer1_channel0_pin_oe_n, // timer pin enable, low while driving
   output logic timer1_channel0_pin_o, // timer pin output data
   output logic capture_ch0_in, // capture input to timer channel 0
   output logic analog_enable, // analog circuit powered
   output logic reference_input_select, // 1 selects internal reference
   output logic bandgap_buffer_enable, // bandgap buffer on
   output logic irq, // interrupt request
   output logic wake_req // wake-up request from wait or light stop
);
   import cmp_pkg::*;

   logic comparator_module_enable_ff; // module enable
   logic reference_input_select_ff; // reference select
   logic compare_event_flag_ff; // sticky event flag
   logic compare_interrupt_enable_ff; // interrupt enable
   logic comparator_pin_output_enable_ff; // pin output enable
   logic [1:0] compare_event_select_ff; // event select
   logic comparator_to_capture_route_ff; // route to capture
   logic bandgap_buffer_enable_ff; // bandgap buffer enable
   logic [7:0] rdata_ff; // read data register
   logic pin_ff, pin_oe_n_ff, tpin_oe_n_ff, tpin_ff, cap_ff; // pin registers
   logic irq_ff, wake_ff; // request registers
   logic level_sync; // synchronised comparator level
   logic event_pulse; // selected edge seen

   // deep stop drops the block; debug changes nothing, wait and light stop only allow wake-up requests
   wire deep_stop = (power_mode == pm_stop_deep);
   wire low_power = (power_mode == pm_wait) || (power_mode == pm_stop_light);
   wire running = comparator_module_enable_ff & ~deep_stop;
   wire level_live = running & level_sync;
   wire wr_ctrl = wr & (addr == reg_status_control); // control write
   wire wr_opt = wr & (addr == reg_system_options); // options write
   wire wr_pwr = wr & (addr == reg_power_mgmt); // power write
   wire flag_clr = wr_ctrl & wdata[bit_flag]; // write one clears
   wire flag_set = event_pulse & running;
   wire nxt_flag = flag_set | (compare_event_flag_ff & ~flag_clr);

   // status and control readback, level bit is live
   wire [7:0] ctrl_view = {comparator_module_enable_ff, reference_input_select_ff,
      compare_event_flag_ff, compare_interrupt_enable_ff, level_live,
      comparator_pin_output_enable_ff, compare_event_select_ff};
   wire [7:0] rd_mux = (addr == reg_status_control) ? ctrl_view :
      (addr == reg_system_options) ? {7'h00, comparator_to_capture_route_ff} :
      (addr == reg_power_mgmt) ? {7'h00, bandgap_buffer_enable_ff} : 8'h00;

   // pin and route decode
   wire drive_pin = running & comparator_pin_output_enable_ff;
   wire route = comparator_to_capture_route_ff;
   wire nxt_cap = route ? level_live : timer_pin_in;
   wire nxt_irq = compare_event_flag_ff & compare_interrupt_enable_ff;
   wire nxt_wake = nxt_irq & low_power;

   // synchroniser ahead of edge detection
   cmp_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .async_in(analog_out),
      .sync_out(level_sync)
   );

   // edge detection; held clear while disabled or powered down
   cmp_edge u_edge (
      .mclk(mclk),
      .rst(rst),
      .clr(~running),
      .level(level_sync),
      .sel(compare_event_select_ff),
      .event_pulse(event_pulse)
   );

   // control register; deep stop forces reset state so wake-up starts clean
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {comparator_module_enable_ff, reference_input_select_ff, compare_event_flag_ff,
            compare_interrupt_enable_ff} <= ctrl_reset[7:4];
         comparator_pin_output_enable_ff <= ctrl_reset[bit_pin_oe];
         compare_event_select_ff <= ctrl_reset[bit_mode_hi:bit_mode_lo];
      end else if (deep_stop) begin
         {comparator_module_enable_ff, reference_input_select_ff, compare_event_flag_ff,
            compare_interrupt_enable_ff} <= ctrl_reset[7:4];
         comparator_pin_output_enable_ff <= ctrl_reset[bit_pin_oe];
         compare_event_select_ff <= ctrl_reset[bit_mode_hi:bit_mode_lo];
      end else begin
         compare_event_flag_ff <= nxt_flag;
         if (wr_ctrl) begin
            comparator_module_enable_ff <= wdata[bit_enable];
            reference_input_select_ff <= wdata[bit_ref_sel];
            compare_interrupt_enable_ff <= wdata[bit_int_en];
            comparator_pin_output_enable_ff <= wdata[bit_pin_oe];
            compare_event_select_ff <= wdata[bit_mode_hi:bit_mode_lo];
         end
      end
   end

   // system option bits live outside the block's power domain
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         comparator_to_capture_route_ff <= 1'b0;
         bandgap_buffer_enable_ff <= 1'b0;
      end else begin
         if (wr_opt) comparator_to_capture_route_ff <= wdata[bit_route];
         if (wr_pwr) bandgap_buffer_enable_ff <= wdata[bit_bandgap];
      end
   end

   // read data stands only in the cycle after rd
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= rd ? rd_mux : 8'h00;
      end
   end

   // registered pins and requests
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_ff <= 1'b0;
         pin_oe_n_ff <= 1'b1;
         tpin_oe_n_ff <= 1'b1;
         tpin_ff <= 1'b0;
         cap_ff <= 1'b0;
         irq_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         pin_ff <= drive_pin & level_sync;
         pin_oe_n_ff <= ~drive_pin;
         tpin_oe_n_ff <= route ? 1'b1 : 1'b0;
         tpin_ff <= route ? 1'b0 : timer_pin_out;
         cap_ff <= nxt_cap;
         irq_ff <= nxt_irq;
         wake_ff <= nxt_wake;
      end
   end

   assign rdata = rdata_ff;
   assign comparator_output_pin = pin_ff;
   assign comparator_output_pin_oe_n = pin_oe_n_ff;
   assign timer1_channel0_pin_oe_n = tpin_oe_n_ff;
   assign timer1_channel0_pin_o = tpin_ff;
   assign capture_ch0_in = cap_ff;
   assign analog_enable = comparator_module_enable_ff;
   assign reference_input_select = reference_input_select_ff;
   assign bandgap_buffer_enable = bandgap_buffer_enable_ff;
   assign irq = irq_ff;
   assign wake_req = wake_ff;
endmodule : cmp_ctrl

/* cmp_pkg.sv */
// constants shared by the comparator control block
package cmp_pkg;
   // register indices on the plain register port
   localparam logic [1:0] reg_status_control = 2'h0; // status and control register
   localparam logic [1:0] reg_system_options = 2'h1; // routing bit for capture channel
   localparam logic [1:0] reg_power_mgmt = 2'h2; // bandgap buffer enable
   localparam int addr_w = 2; // register address width
   // status and control field positions
   localparam int bit_enable = 7; // module enable
   localparam int bit_ref_sel = 6; // reference input select
   localparam int bit_flag = 5; // compare event flag
   localparam int bit_int_en = 4; // interrupt enable
   localparam int bit_level = 3; // comparator output level
   localparam int bit_pin_oe = 2; // pin output enable
   localparam int bit_mode_hi = 1; // event select high bit
   localparam int bit_mode_lo = 0; // event select low bit
   localparam int bit_route = 0; // routing bit in system options
   localparam int bit_bandgap = 0; // bandgap buffer enable bit
   localparam logic [7:0] ctrl_reset = 8'h00; // reset value of control
   // event select encodings
   typedef enum logic [1:0] {
      ev_fall0 = 2'h0,
      ev_rise = 2'h1,
      ev_fall2 = 2'h2,
      ev_both = 2'h3
   } event_sel_t;
   // power modes, gray coded along run, wait, light stop, deep stop
   typedef enum logic [1:0] {
      pm_run = 2'h0,
      pm_wait = 2'h1,
      pm_stop_light = 2'h3,
      pm_stop_deep = 2'h2
   } power_mode_t;
endpackage : cmp_pkg

/* cmp_sync.sv */
// two-flop synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
module cmp_sync (
   input wire logic mclk, // bus clock
   input wire logic rst, // async reset, active high
   input wire logic async_in, // raw comparator output
   output logic sync_out // synchronised level
);
   logic meta_ff; // first stage, read only by second stage
   // two stages; the first is never looked at by anything else
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule : cmp_sync

/* cmp_edge.sv */
// edge detector with selectable event type
`timescale 1ns/1ps
module cmp_edge
   import cmp_pkg::*;
(
   input wire logic mclk, // bus clock
   input wire logic rst, // async reset, active high
   input wire logic clr, // mask event output, history keeps tracking
   input wire logic level, // synchronised comparator level
   input wire logic [1:0] sel, // event select
   output logic event_pulse // one-cycle event
);
   logic prev_ff; // previous level
   wire rise = level & ~prev_ff; // rising transition
   wire fall = ~level & prev_ff; // falling transition
   // decode selected edge
   wire hit = (sel == ev_rise) ? rise : (sel == ev_both) ? (rise | fall) : fall;
   // history tracks level even while disabled, so enabling on a high level gives no edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= level;
      end
   end
   assign event_pulse = hit & ~clr;
endmodule : cmp_edge

/* cmp_analog_model.sv */
// behavioural model of the analog comparator in front of the control block
`timescale 1ns/1ps
module cmp_analog_model #(
   parameter logic [7:0] bandgap_lvl = 8'h80 // internal reference level, plain default
) (
   input wire logic powered, // analog circuit on
   input wire logic ref_sel, // compare against internal reference
   input wire logic buf_on, // bandgap buffer on
   input wire logic [7:0] pos_in, // noninverting_input_pin level
   input wire logic [7:0] neg_in, // inverting_input_pin level
   output logic analog_out // raw comparator output
);
   // an unbuffered reference is junk, so software must turn the buffer on first
   wire logic [7:0] plus_lvl = ref_sel ? (buf_on ? bandgap_lvl : ~neg_in) : pos_in;
   // a powered-down comparator holds its output low
   assign analog_out = powered & (plus_lvl > neg_in);
endmodule : cmp_analog_model

/* cmp_ctrl_chk.sv */
// port-level assertions for the comparator control block
`timescale 1ns/1ps
module cmp_ctrl_chk
   import cmp_pkg::*;
(
   input wire logic mclk, // bus clock
   input wire logic rst, // async reset
   input wire logic [cmp_pkg::addr_w-1:0] addr, // register index
   input wire logic rd, // read strobe
   input wire logic [7:0] rdata, // read data
   input wire logic [1:0] power_mode, // power mode
   input wire logic analog_out, // raw level
   input wire logic comparator_output_pin, // pin data
   input wire logic comparator_output_pin_oe_n, // pin enable
   input wire logic timer1_channel0_pin_oe_n, // timer pin enable
   input wire logic capture_ch0_in, // capture input
   input wire logic analog_enable, // module on
   input wire logic irq, // interrupt
   input wire logic wake_req // wake-up
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // the pipeline is at most two flops deep (flag then irq), so deep stop must have lasted three cycles
   property p_deep_pin; (power_mode == pm_stop_deep) [*3] |-> comparator_output_pin_oe_n; endproperty
   property p_deep_irq; (power_mode == pm_stop_deep) [*3] |-> !irq && !wake_req; endproperty
   property p_pin_off; comparator_output_pin_oe_n |-> !comparator_output_pin; endproperty
   property p_pin_follow; (!comparator_output_pin_oe_n && $stable(analog_out)) [*5]
      |-> comparator_output_pin == analog_out; endproperty
   property p_route_cap; (timer1_channel0_pin_oe_n && $stable(analog_out)) [*5]
      |-> capture_ch0_in == analog_out; endproperty
   property p_wake_irq; wake_req |-> irq; endproperty
   property p_wake_mode; (irq && power_mode inside {pm_wait, pm_stop_light}) [*2] |-> wake_req;
   endproperty
   property p_no_wake; !($past(power_mode) inside {pm_wait, pm_stop_light}) |-> !wake_req;
   endproperty
   property p_level_off; rd && addr == reg_status_control && !analog_enable
      |=> !rdata[bit_level]; endproperty
   property p_irq_read; rd && addr == reg_status_control
      |=> irq == (rdata[bit_flag] && rdata[bit_int_en]); endproperty
   a_deep_pin: assert property (p_deep_pin) else $error("pin enabled in deep stop");
   a_deep_irq: assert property (p_deep_irq) else $error("request in deep stop");
   a_pin_off: assert property (p_pin_off) else $error("pin data while released");
   a_pin_follow: assert property (p_pin_follow) else $error("pin not following");
   a_route_cap: assert property (p_route_cap) else $error("capture not routed");
   a_wake_irq: assert property (p_wake_irq) else $error("wake without irq");
   a_wake_mode: assert property (p_wake_mode) else $error("no wake in low power");
   a_no_wake: assert property (p_no_wake) else $error("wake in wrong mode");
   a_level_off: assert property (p_level_off) else $error("level read while off");
   a_irq_read: assert property (p_irq_read) else $error("irq not flag and enable");
   c_wake: cover property (wake_req && power_mode == pm_stop_light);
   c_route: cover property (timer1_channel0_pin_oe_n && capture_ch0_in);
   c_deep: cover property ((power_mode == pm_stop_deep) [*3]);
endmodule : cmp_ctrl_chk

bind cmp_ctrl cmp_ctrl_chk u_chk (.mclk, .rst, .addr, .rd, .rdata, .power_mode, .analog_out,
   .comparator_output_pin, .comparator_output_pin_oe_n, .timer1_channel0_pin_oe_n,
   .capture_ch0_in, .analog_enable, .irq, .wake_req);

/* tb_top.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_top;
   import cmp_pkg::*;
   logic mclk = 1'b0; // bus clock
   logic rst = 1'b1; // reset
   logic [1:0] addr = 2'h0; // register index
   logic [7:0] wdata = 8'h00; // write data
   logic wr = 1'b0; // write strobe
   logic rd = 1'b0; // read strobe
   logic [1:0] power_mode = pm_run; // power mode
   logic dbg = 1'b0; // debug active
   logic timer_in = 1'b0; // timer pin level
   logic [7:0] pos_in = 8'h10; // plus input level
   logic [7:0] neg_in = 8'h40; // minus input level
   logic analog_out, pin, pin_oe_n, t_oe_n, cap, a_en, ref_sel, bg_en, irq, wake_req;
   logic t_o; // timer pin data toward the pad
   logic [7:0] rdata; // read data
   logic [7:0] d; // last read
   int num_errors = 0;
   int check_count = 0;
   int cyc = 0;
   // rows: event select, level before, level after, expected flag
   logic [4:0] rows [8] = '{5'b00_10_1, 5'b00_01_0, 5'b01_01_1, 5'b01_10_0,
                            5'b10_10_1, 5'b10_01_0, 5'b11_01_1, 5'b11_10_1};
   cmp_ctrl DUT (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .power_mode,
      .debug_active(dbg), .analog_out, .timer_pin_in(timer_in), .timer_pin_out(timer_in),
      .comparator_output_pin(pin), .comparator_output_pin_oe_n(pin_oe_n),
      .timer1_channel0_pin_oe_n(t_oe_n), .timer1_channel0_pin_o(t_o), .capture_ch0_in(cap),
      .analog_enable(a_en), .reference_input_select(ref_sel), .bandgap_buffer_enable(bg_en),
      .irq, .wake_req);
   cmp_analog_model u_model (.powered(a_en), .ref_sel, .buf_on(bg_en), .pos_in, .neg_in,
      .analog_out);
   always #4 mclk = ~mclk;
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [1:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      dbg <= 1'b1;
      // edge select table, run with debug active
      for (int i = 0; i < 8; i++) begin
         pos_in <= rows[i][2] ? 8'h60 : 8'h10;
         wr_reg(reg_status_control, 8'ha0 | rows[i][4:3]);
         repeat (6) @(posedge mclk);
         wr_reg(reg_status_control, 8'ha0 | rows[i][4:3]);
         pos_in <= rows[i][1] ? 8'h60 : 8'h10;
         repeat (6) @(posedge mclk);
         rd_reg(reg_status_control);
         check(d[bit_flag], rows[i][0]);
         check(d[bit_level], rows[i][1]);
      end
      dbg <= 1'b0;
      wr_reg(reg_status_control, 8'h93);
      repeat (2) @(posedge mclk);
      check(irq, 1'b1);
      rd_reg(reg_status_control);
      check(d[bit_flag], 1'b1);
      wr_reg(reg_status_control, 8'hb3);
      rd_reg(reg_status_control);
      check(d[bit_flag], 1'b0);
      power_mode <= pm_wait;
      pos_in <= 8'h60;
      repeat (6) @(posedge mclk);
      check(wake_req, 1'b1);
      wr_reg(reg_status_control, 8'hb7);
      power_mode <= pm_stop_light;
      pos_in <= 8'h10;
      repeat (6) @(posedge mclk);
      check(wake_req, 1'b1);
      check({pin_oe_n, pin}, 2'b00);
      pos_in <= 8'h60;
      repeat (6) @(posedge mclk);
      check({pin_oe_n, pin}, 2'b01);
      power_mode <= pm_stop_deep;
      repeat (4) @(posedge mclk);
      check({pin_oe_n, wake_req}, 2'b10);
      power_mode <= pm_run;
      rd_reg(reg_status_control);
      check(d, ctrl_reset);
      power_mode <= pm_wait;
      pos_in <= 8'h10;
      repeat (6) @(posedge mclk);
      check({a_en, wake_req}, 2'b00);
      power_mode <= pm_run;
      wr_reg(reg_system_options, 8'h01);
      wr_reg(reg_power_mgmt, 8'h01);
      wr_reg(reg_status_control, 8'hc0);
      repeat (6) @(posedge mclk);
      check({bg_en, t_oe_n, cap}, 3'b111);
      timer_in <= 1'b1;
      repeat (2) @(posedge mclk);
      check({t_oe_n, t_o}, 2'b10);
      timer_in <= 1'b0;
      neg_in <= 8'hf0;
      repeat (6) @(posedge mclk);
      check(cap, 1'b0);
      rd_reg(2'h3);
      check(d, 8'h00);
      wr_reg(reg_system_options, 8'h00);
      timer_in <= 1'b1;
      repeat (3) @(posedge mclk);
      check({t_oe_n, cap}, 2'b01);
      check(t_o, 1'b1);
      power_mode <= pm_stop_light;
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      power_mode <= pm_run;
      rd_reg(reg_status_control);
      check(d, ctrl_reset);
      test_done();
   end
endmodule : tb_top
